/* File: hw/gpe_sync.sv */
// Two-flop synchroniser and edge detector for every pin.
// Assumes pins are asynchronous to ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
module gpe_sync #(
  parameter int W = 32
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic [W-1:0] pin_in,
  gpe_pin_if.src pins
);
  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] prev;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_stable;
  logic [W-1:0] next_prev;

  // Next values: first flop feeds only the second
  always_comb begin
    next_meta = pin_in;
    next_stable = meta;
    next_prev = stable;
  end

  // Register the chain
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

  // Edge pulses from the stable level
  assign pins.level = stable;
  assign pins.rise = stable & ~prev;
  assign pins.fall = ~stable & prev;

  a_level_sync_depth: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    $past(srst_in, 3) == 1'b0 |-> stable == $past(pin_in, gpe_pkg::SYNC_CYCLES))
    else $error("Pin level not two cycles behind pin");
endmodule : gpe_sync
`default_nettype wire

/* File: hw/gpe_top.sv */
// Edge-interrupt detection for a 32-pin port with an AHB-Lite slave.
// Assumes one 20 MHz clock, synchronous reset and word-only transfers.
`timescale 1ns/1ps
`default_nettype none
module gpe_top #(
  parameter int PINS = gpe_pkg::PIN_W
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic hsel_in,
  input wire logic [gpe_pkg::ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [PINS-1:0] gpio_pin_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic irq_out
);
  // Pin side
  gpe_pin_if #(.W(PINS)) pio ();

  gpe_sync #(
    .W(PINS)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .pin_in(gpio_pin_in),
    .pins(pio)
  );

  // Bus slave state
  gpe_pkg::gpe_bus_state_t state;
  gpe_pkg::gpe_bus_state_t next_state;
  logic [gpe_pkg::ADDR_W-1:0] addr;
  logic [gpe_pkg::ADDR_W-1:0] next_addr;
  logic is_write;
  logic next_is_write;
  logic size_ok;
  logic next_size_ok;
  logic take;

  // Register state
  logic [PINS-1:0] rise_en;
  logic [PINS-1:0] next_rise_en;
  logic [PINS-1:0] fall_en;
  logic [PINS-1:0] next_fall_en;
  logic [PINS-1:0] pend;
  logic [PINS-1:0] next_pend;
  logic [PINS-1:0] irq_en;
  logic [PINS-1:0] next_irq_en;
  logic [31:0] next_rdata;
  logic next_readyout;
  logic next_irq;

  // Access strobes
  logic wr;
  logic rd;
  logic [PINS-1:0] wdata;
  logic [PINS-1:0] ev;
  logic [PINS-1:0] clr_mask;

  // Address phase is taken when the bus is ready, the slave is selected and the transfer is NONSEQ
  assign take = hsel_in && hready_in && (htrans_in == gpe_pkg::HTRANS_NONSEQ);

  // Bus state: one wait cycle in which the access is done
  always_comb begin
    next_state = state;
    next_addr = addr;
    next_is_write = is_write;
    next_size_ok = size_ok;
    next_readyout = 1'b1;
    case (state)
      gpe_pkg::GPE_IDLE: begin
        if (take) begin
          next_state = gpe_pkg::GPE_ACCESS;
          next_addr = haddr_in;
          next_is_write = hwrite_in;
          next_size_ok = (hsize_in == gpe_pkg::HSIZE_WORD);
          next_readyout = 1'b0;
        end
      end
      gpe_pkg::GPE_ACCESS: begin
        next_state = gpe_pkg::GPE_IDLE;
      end
      default: begin
        next_state = gpe_pkg::GPE_IDLE;
      end
    endcase
  end

  // Register the bus state
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state <= gpe_pkg::GPE_IDLE;
      addr <= '0;
      is_write <= 1'b0;
      size_ok <= 1'b0;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      is_write <= next_is_write;
      size_ok <= next_size_ok;
      hreadyout_out <= next_readyout;
      hresp_out <= 1'b0; // Always OKAY
    end
  end

  // Strobes for the access cycle; write data stands in the data phase
  assign wr = (state == gpe_pkg::GPE_ACCESS) && is_write && size_ok;
  assign rd = (state == gpe_pkg::GPE_ACCESS) && !is_write && size_ok;
  assign wdata = hwdata_in[PINS-1:0];

  // Enabled edges become events
  assign ev = (pio.rise & rise_en) | (pio.fall & fall_en);

  // Bits cleared by either the pending or the clear register
  always_comb begin
    clr_mask = '0;
    if (wr && addr == gpe_pkg::OFS_PENDING) begin
      clr_mask = wdata;
    end else if (wr && addr == gpe_pkg::OFS_IRQ_CLR) begin
      clr_mask = wdata;
    end
  end

  // Next register values
  always_comb begin
    next_rise_en = rise_en;
    next_fall_en = fall_en;
    next_irq_en = irq_en;
    if (wr && addr == gpe_pkg::OFS_RISE_SET) begin
      next_rise_en = rise_en | wdata;
    end else if (wr && addr == gpe_pkg::OFS_RISE_CLR) begin
      next_rise_en = rise_en & ~wdata;
    end else if (wr && addr == gpe_pkg::OFS_FALL_SET) begin
      next_fall_en = fall_en | wdata;
    end else if (wr && addr == gpe_pkg::OFS_FALL_CLR) begin
      next_fall_en = fall_en & ~wdata;
    end else if (wr && addr == gpe_pkg::OFS_IRQ_EN) begin
      next_irq_en = wdata;
    end
    // Set wins over clear
    next_pend = (pend & ~clr_mask) | ev;
  end

  // Register the enables and pending bits
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rise_en <= gpe_pkg::RST_ENABLE[PINS-1:0];
      fall_en <= gpe_pkg::RST_ENABLE[PINS-1:0];
      irq_en <= gpe_pkg::RST_ENABLE[PINS-1:0];
      pend <= gpe_pkg::RST_PENDING[PINS-1:0];
    end else begin
      rise_en <= next_rise_en;
      fall_en <= next_fall_en;
      irq_en <= next_irq_en;
      pend <= next_pend;
    end
  end

  // Read data: captured in the access cycle, unmapped reads give zero
  always_comb begin
    next_rdata = hrdata_out;
    if (rd) begin
      next_rdata = '0;
      if (addr == gpe_pkg::OFS_RISE_SET) begin
        next_rdata[PINS-1:0] = rise_en;
      end else if (addr == gpe_pkg::OFS_RISE_CLR) begin
        next_rdata[PINS-1:0] = ~rise_en;
      end else if (addr == gpe_pkg::OFS_FALL_SET) begin
        next_rdata[PINS-1:0] = fall_en;
      end else if (addr == gpe_pkg::OFS_FALL_CLR) begin
        next_rdata[PINS-1:0] = ~fall_en;
      end else if (addr == gpe_pkg::OFS_PENDING) begin
        next_rdata[PINS-1:0] = pend;
      end else if (addr == gpe_pkg::OFS_LEVEL) begin
        next_rdata[PINS-1:0] = pio.level;
      end else if (addr == gpe_pkg::OFS_IRQ_EN) begin
        next_rdata[PINS-1:0] = irq_en;
      end
    end
    // Interrupt line from the enabled pending bits
    next_irq = |(pend & irq_en);
  end

  // Register read data and interrupt
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      hrdata_out <= gpe_pkg::RST_RDATA;
      irq_out <= 1'b0;
    end else begin
      hrdata_out <= next_rdata;
      irq_out <= next_irq;
    end
  end

  // Write and read strobes per register, used by the checks below
  logic w_rs;
  logic w_rc;
  logic w_fs;
  logic w_fc;
  logic r_rc;
  logic r_fc;
  assign w_rs = wr && addr == gpe_pkg::OFS_RISE_SET;
  assign w_rc = wr && addr == gpe_pkg::OFS_RISE_CLR;
  assign w_fs = wr && addr == gpe_pkg::OFS_FALL_SET;
  assign w_fc = wr && addr == gpe_pkg::OFS_FALL_CLR;
  assign r_rc = rd && addr == gpe_pkg::OFS_RISE_CLR;
  assign r_fc = rd && addr == gpe_pkg::OFS_FALL_CLR;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  // Set writes enable ones and keep the rest
  a_rise_set_write: assert property (
    w_rs |=> (rise_en == ($past(rise_en) | $past(wdata))))
    else $error("Rising set write wrong");
  a_fall_set_write: assert property (
    w_fs |=> (fall_en == ($past(fall_en) | $past(wdata))))
    else $error("Falling set write wrong");

  // Clear writes disable ones and keep the rest
  a_rise_clr_write: assert property (
    w_rc |=> (rise_en == ($past(rise_en) & ~$past(wdata))))
    else $error("Rising clear write wrong");
  a_fall_clr_write: assert property (
    w_fc |=> (fall_en == ($past(fall_en) & ~$past(wdata))))
    else $error("Falling clear write wrong");

  // Clear registers read as complement
  a_rise_clr_read: assert property (
    r_rc |=> hrdata_out[PINS-1:0] == ~rise_en)
    else $error("Rising clear read not complement");
  a_fall_clr_read: assert property (
    r_fc |=> hrdata_out[PINS-1:0] == ~fall_en)
    else $error("Falling clear read not complement");

  // Rising and falling enables are zero just after reset
  a_reset_enables: assert property (
    $fell(srst_in) |-> (rise_en == '0 && fall_en == '0))
    else $error("Enables not zero after reset");

  // Edge pulses follow level changes
  a_rise_edge_level: assert property (
    (pio.rise & ~(pio.level & ~$past(pio.level))) == '0)
    else $error("Rising pulse without low-to-high");
  a_fall_edge_level: assert property (
    (pio.fall & ~(~pio.level & $past(pio.level))) == '0)
    else $error("Falling pulse without high-to-low");

  // Every event lands in its pending bit, even against a clear
  a_event_recorded: assert property (
    ev != '0 |=> (pend & $past(ev)) == $past(ev))
    else $error("Event not recorded");
  a_pend_no_spurious: assert property (
    (pend & ~$past(pend) & ~$past(ev)) == '0)
    else $error("Pending bit set without event");

  // Write one to clear, zeros ignored
  a_pend_w1c: assert property (
    (wr && addr == gpe_pkg::OFS_PENDING) |=>
      pend == (($past(pend) & ~$past(wdata)) | $past(ev)))
    else $error("Pending clear wrong");
  a_event_beats_clear: assert property (
    (ev & clr_mask) != '0 |=> (pend & $past(ev & clr_mask)) == $past(ev & clr_mask))
    else $error("Clear won over a new event");

  // Interrupt follows enabled pending bits one cycle later
  a_irq_level: assert property (
    irq_out == |($past(pend) & $past(irq_en)))
    else $error("Interrupt level wrong");

  // Each access takes exactly one wait cycle
  a_bus_wait_one: assert property (
    (state == gpe_pkg::GPE_IDLE && take) |=> !hreadyout_out ##1 hreadyout_out)
    else $error("Bus wait not one cycle");

  // Main scenarios
  c_rise_event: cover property (|(pio.rise & rise_en));
  c_fall_event: cover property (|(pio.fall & fall_en));
  c_clear_collision: cover property (|(ev & clr_mask));
  c_irq_raised: cover property ($rose(irq_out));
endmodule : gpe_top
`default_nettype wire

/* File: pkg/gpe_pin_if.sv */
// Carries the synchronised pin levels and their edge pulses.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface gpe_pin_if #(parameter int W = 32);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : gpe_pin_if
`default_nettype wire

/* File: pkg/gpe_pkg.sv */
// Shared constants for the edge-interrupt block of the general-purpose port.
// Assumes a 32-bit AHB-Lite register bus and a single 20 MHz clock.
`default_nettype none
package gpe_pkg;
  // Port layout: two banks of sixteen pins
  localparam int BANK_W = 16;
  localparam int PIN_W = 2 * BANK_W;
  localparam int BANK_LO_LSB = 0;
  localparam int BANK_HI_LSB = 16;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_RISE_SET = 8'h00;
  localparam logic [7:0] OFS_RISE_CLR = 8'h04;
  localparam logic [7:0] OFS_FALL_SET = 8'h08;
  localparam logic [7:0] OFS_FALL_CLR = 8'h0C;
  localparam logic [7:0] OFS_PENDING = 8'h10;
  localparam logic [7:0] OFS_LEVEL = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
  // Values after reset
  localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_PENDING = 32'h0000_0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Synchroniser depth in cycles
  localparam int SYNC_CYCLES = 2;
  // Bus slave states
  typedef enum logic [1:0] {
    GPE_IDLE = 2'b01,
    GPE_ACCESS = 2'b10
  } gpe_bus_state_t;
endpackage : gpe_pkg
`default_nettype wire

/* File: tb/gpe_pin_model.sv */
// Stand-in for the external circuits wired to the 32 port pins.
// Assumes the bench changes levels only through set_levels.
`timescale 1ns/1ps
`default_nettype none
module gpe_pin_model (
  input wire logic ref_clk_in,
  output var logic [31:0] pin_out
);
  // Pins start low and are always driven, so no level floats
  initial pin_out = 32'h0000_0000;

  // New levels land just after a clock edge and then hold
  task automatic set_levels(input logic [31:0] v);
    @(posedge ref_clk_in);
    pin_out <= v;
  endtask : set_levels
endmodule : gpe_pin_model
`default_nettype wire

/* File: tb/gpe_tb_top.sv */
// Self-checking bench for the edge-interrupt block of the port.
// Assumes gpe_top answers each bus transfer after one wait state.
`timescale 1ns/1ps
`default_nettype none
module gpe_tb_top;
  typedef struct {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] ex;
  } gpe_row_t;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic hsel = 1'b0;
  logic [gpe_pkg::ADDR_W-1:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [2:0] xsize = gpe_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic irq;
  logic [31:0] pins;
  logic [31:0] rd;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  gpe_row_t rows [9];

  gpe_pin_model pm (.ref_clk_in(ref_clk_in), .pin_out(pins));

  gpe_top uut (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .hsel_in(hsel),
    .haddr_in(haddr),
    .htrans_in(htrans),
    .hwrite_in(hwrite),
    .hsize_in(hsize),
    .hwdata_in(hwdata),
    .hready_in(hready),
    .gpio_pin_in(pins),
    .hrdata_out(hrdata),
    .hreadyout_out(hready),
    .hresp_out(hresp),
    .irq_out(irq)
  );

  // 20 MHz clock
  always #25 ref_clk_in = ~ref_clk_in;

  // Cut a hang short well beyond the expected few hundred cycles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      wrap_up();
    end
  end

  // Compare one value and count it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One single AHB-Lite transfer of size xsize; read data lands in rd
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= gpe_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= xsize;
    do @(posedge ref_clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk_in); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask : xfer

  // Read a register and compare it
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rc

  // Change pins and let synchroniser, detector and pending flop settle
  task automatic pin_step(input logic [31:0] v);
    pm.set_levels(v);
    repeat (6) @(posedge ref_clk_in);
  endtask : pin_step

  // Final counts and verdict
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    rows[0] = '{8'h00, 32'hA5A5_0001, 8'h00, 32'hA5A5_0001};
    rows[1] = '{8'h00, 32'h0000_0000, 8'h00, 32'hA5A5_0001};
    rows[2] = '{8'h04, 32'hFFFF_0000, 8'h04, 32'hFFFF_FFFE};
    rows[3] = '{8'h04, 32'h0000_0000, 8'h00, 32'h0000_0001};
    rows[4] = '{8'h08, 32'h8000_8000, 8'h08, 32'h8000_8000};
    rows[5] = '{8'h08, 32'h0000_0000, 8'h0C, 32'h7FFF_7FFF};
    rows[6] = '{8'h0C, 32'h0000_8000, 8'h08, 32'h8000_0000};
    rows[7] = '{8'h30, 32'hFFFF_FFFF, 8'h30, 32'h0000_0000};
    rows[8] = '{8'h18, 32'hFFFF_FFFF, 8'h18, 32'hFFFF_FFFF};
    repeat (3) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    // Values after reset
    rc(8'h00, 32'h0000_0000);
    rc(8'h04, 32'hFFFF_FFFF);
    rc(8'h08, 32'h0000_0000);
    rc(8'h0C, 32'hFFFF_FFFF);
    rc(8'h10, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    // Register table: write, then read back
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].wa, rows[i].wd);
      rc(rows[i].ra, rows[i].ex);
    end
    // A byte-sized write is refused and changes nothing
    xsize = 3'h0;
    xfer(1'b1, 8'h00, 32'hFFFF_FFFF);
    xsize = gpe_pkg::HSIZE_WORD;
    rc(8'h00, 32'h0000_0001);
    // Rising on pins 0, 5, 31; only pin 0 has rising enabled
    pin_step(32'h8000_0021);
    rc(8'h14, 32'h8000_0021);
    rc(8'h10, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    // Falling on pins 0, 5, 31; only pin 31 has falling enabled
    pin_step(32'h0000_0000);
    rc(8'h10, 32'h8000_0001);
    xfer(1'b1, 8'h10, 32'h0000_0000);
    rc(8'h10, 32'h8000_0001);
    xfer(1'b1, 8'h10, 32'h8000_0000);
    rc(8'h10, 32'h0000_0001);
    xfer(1'b1, 8'h1C, 32'h0000_0001);
    repeat (2) @(posedge ref_clk_in);
    chk({31'h0, irq}, 32'h0000_0000);
    // Rising disabled on pin 0
    xfer(1'b1, 8'h04, 32'h0000_0001);
    pin_step(32'h0000_0001);
    rc(8'h10, 32'h0000_0000);
    // Both directions on pin 3
    xfer(1'b1, 8'h00, 32'h0000_0008);
    xfer(1'b1, 8'h08, 32'h0000_0008);
    pin_step(32'h0000_0009);
    rc(8'h10, 32'h0000_0008);
    xfer(1'b1, 8'h10, 32'h0000_0008);
    pin_step(32'h0000_0001);
    rc(8'h10, 32'h0000_0008);
    // Falling disabled on pin 3, rising still on
    xfer(1'b1, 8'h0C, 32'h0000_0008);
    xfer(1'b1, 8'h10, 32'h0000_0008);
    pin_step(32'h0000_0009);
    xfer(1'b1, 8'h10, 32'h0000_0008);
    pin_step(32'h0000_0001);
    rc(8'h10, 32'h0000_0000);
    // Masking the interrupt line with a bit pending
    pin_step(32'h0000_0009);
    xfer(1'b1, 8'h18, 32'h0000_0000);
    repeat (2) @(posedge ref_clk_in);
    chk({31'h0, irq}, 32'h0000_0000);
    xfer(1'b1, 8'h18, 32'h0000_0008);
    repeat (2) @(posedge ref_clk_in);
    chk({31'h0, irq}, 32'h0000_0001);
    // Rising event on pin 3 lands in the cycle its clear is applied
    pin_step(32'h0000_0001);
    fork
      pm.set_levels(32'h0000_0009);
      begin
        @(posedge ref_clk_in);
        xfer(1'b1, 8'h10, 32'h0000_0008);
      end
    join
    rc(8'h10, 32'h0000_0008);
    // Reset in mid-run
    @(posedge ref_clk_in);
    srst_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    rc(8'h00, 32'h0000_0000);
    rc(8'h08, 32'h0000_0000);
    rc(8'h10, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wrap_up();
  end
endmodule : gpe_tb_top
`default_nettype wire
